// ===== sdci_defines.svh
// Purpose: constants for the serial disk command interface
// Assumes: 125 MHz mclk_i
// Notes: opcode choices and masks are named once here
`ifndef SDCI_DEFINES_SVH
`define SDCI_DEFINES_SVH

// clock period and handshake timing
`define SDCI_CLK_NS      8
`define SDCI_ACK_NS      2000
`define SDCI_ACK_CYC     ((`SDCI_ACK_NS) / (`SDCI_CLK_NS))
`define SDCI_ATTN_NS     100
`define SDCI_ATTN_CYC    ((`SDCI_ATTN_NS + `SDCI_CLK_NS - 1) / (`SDCI_CLK_NS))

// serial word: 16 data bits then parity, msb first
`define SDCI_XFER_BITS   5'h11
`define SDCI_OP_MSB      16
`define SDCI_OP_LSB      13
`define SDCI_MOD_MSB     12
`define SDCI_MOD_LSB     9
`define SDCI_PRM_MSB     12
`define SDCI_PRM_LSB     1

// opcodes with special handling
`define SDCI_OP_STATUS   4'h2
`define SDCI_OP_CONFIG   4'h3
`define SDCI_OP_MOTOR    4'h5

// one bit per opcode
`define SDCI_IMPL_MASK   16'h00FF
`define SDCI_PARAM_MASK  16'h0001
`define SDCI_RESTR_MASK  16'h003E

`endif

// ===== sdci_pkg.sv
// Purpose: types for the serial disk command interface
// Assumes: nothing
// Notes: states are one-hot
package sdci_pkg;
    // command interpreter states
    typedef enum logic [5:0] {
        SDCI_IDLE   = 6'h01,
        SDCI_RECV   = 6'h02,
        SDCI_DECODE = 6'h04,
        SDCI_EXEC   = 6'h08,
        SDCI_SEND   = 6'h10,
        SDCI_ATTN   = 6'h20
    } sdci_state_e;
endpackage

// ===== sdci_top.sv
// Purpose: drive-side serial command and status interface
// Assumes: host pins are asynchronous; core signals on mclk_i
// Notes: odd parity over 17 bits; open-collector levels external
`include "sdci_defines.svh"
`timescale 1ns/1ps
module sdci_top (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // straps and host pins
    input  wire logic [2:0]  drive_id_i,
    input  wire logic        motor_cmd_opt_i,
    input  wire logic [2:0]  drv_sel_i,
    input  wire logic        xfer_req_i,
    input  wire logic        cmd_data_i,
    // pins to host
    output logic             drive_selected_o,
    output logic             xfer_ack_o,
    output logic             resp_data_o,
    output logic             cmd_complete_o,
    output logic             attention_o,
    output logic             ready_o,
    // from drive core
    input  wire logic        spindle_ready_i,
    input  wire logic        spin_fail_i,
    input  wire logic [15:0] status_word_i,
    input  wire logic [15:0] config_word_i,
    input  wire logic        exec_done_i,
    input  wire logic        exec_err_i,
    // to drive core
    output logic             exec_start_o,
    output logic [3:0]       exec_opcode_o,
    output logic [3:0]       exec_mod_o,
    output logic [11:0]      exec_param_o,
    output logic             motor_start_o
);
    localparam logic [7:0] ACK_LAST  = 8'(`SDCI_ACK_CYC - 1);
    localparam logic [3:0] ATTN_LAST = 4'(`SDCI_ATTN_CYC - 1);
    localparam logic [15:0] IMPL_MASK  = `SDCI_IMPL_MASK;   // implemented opcodes
    localparam logic [15:0] PARAM_MASK = `SDCI_PARAM_MASK;  // parameter-type opcodes
    localparam logic [15:0] RESTR_MASK = `SDCI_RESTR_MASK;  // allowed before motor start
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    logic [8:0]        sy1;           // synchroniser first stage
    logic [8:0]        sy2;           // synchroniser second stage
    logic [2:0]        id_s;          // jumpered identifier
    logic              mode_s;        // start-by-command strap
    logic [2:0]        sel_s;         // host select code
    logic              req_s;         // transfer request
    logic              dat_s;         // command data line
    logic              sel_m;         // select matches our id
    sdci_pkg::sdci_state_e state;     // interpreter state
    logic [7:0]        hs_cnt;        // acknowledge delay count
    logic              hs_on;         // handshake may advance
    logic              hs_due;        // acknowledge follows request
    logic [4:0]        bitcnt;        // bits moved this word
    logic [16:0]       rx_sh;         // received word and parity
    logic [16:0]       tx_sh;         // outgoing word and parity
    logic [3:0]        atn_cnt;       // attention lead count
    logic              hold;          // ignoring the host
    logic              next_hold;     // hold for next cycle
    logic              motor_started; // motor start accepted
    logic [3:0]        op;            // decoded opcode
    logic              par_bad;       // parity failure
    logic              allow;         // opcode allowed now
    logic              refuse;        // reject this command
    logic [15:0]       rsp_word;      // word to return
    // pin synchroniser, two flops
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sy1 <= 9'h000;
            sy2 <= 9'h000;
        end else begin
            sy1 <= {drive_id_i, motor_cmd_opt_i, drv_sel_i, xfer_req_i, cmd_data_i};
            sy2 <= sy1;
        end
    end
    assign id_s   = sy2[8:6];
    assign mode_s = sy2[5];
    assign sel_s  = sy2[4:2];
    assign req_s  = sy2[1];
    assign dat_s  = sy2[0];
    // zero is never a valid address
    assign sel_m  = (id_s != 3'h0) && (sel_s == id_s);
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            drive_selected_o <= 1'b0;
        end else begin
            drive_selected_o <= sel_m;
        end
    end
    chk_sel_assert: assert property (sel_m [*3] |-> drive_selected_o)
        else $error("drive selected missing");
    chk_sel_release: assert property (!sel_m [*3] |-> !drive_selected_o)
        else $error("drive selected stuck");
    // ready mirrors the spindle
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= spindle_ready_i;
        end
    end
    assign next_hold = !spindle_ready_i && !spin_fail_i && (!mode_s || motor_started);
    // power-up and motor hold
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold <= 1'b1;
        end else begin
            hold <= next_hold;
        end
    end
    chk_hold_quiet: assert property (hold |-> !cmd_complete_o && !xfer_ack_o)
        else $error("host answered during hold");
    // handshake advances only while selected
    assign hs_on  = drive_selected_o && (state == sdci_pkg::SDCI_RECV || state == sdci_pkg::SDCI_SEND);
    assign hs_due = hs_on && (req_s != xfer_ack_o) && (hs_cnt == ACK_LAST);
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hs_cnt <= 8'h00;
        end else if (!hs_on || req_s == xfer_ack_o || hs_due) begin
            hs_cnt <= 8'h00;
        end else begin
            hs_cnt <= hs_cnt + 8'h01;
        end
    end
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            xfer_ack_o <= 1'b0;
        end else if (hs_due) begin
            xfer_ack_o <= req_s;
        end
    end
    chk_ack_delay: assert property ((hs_on && req_s && !xfer_ack_o && hs_cnt == 8'h00)
        |-> !xfer_ack_o [*8] ##[1:300] xfer_ack_o)
        else $error("acknowledge timing wrong");
    // decode of the received word
    always_comb begin
        op       = rx_sh[`SDCI_OP_MSB:`SDCI_OP_LSB];
        // odd parity over all 17 bits
        par_bad  = !(^rx_sh);
        rsp_word = (op == `SDCI_OP_CONFIG) ? config_word_i : status_word_i;
        if (spindle_ready_i) begin
            allow = IMPL_MASK[op];
        end else if (mode_s && !motor_started) begin
            allow = RESTR_MASK[op];
        end else begin
            allow = (op == `SDCI_OP_STATUS);
        end
        refuse = par_bad || !IMPL_MASK[op] || !allow;
    end
    // interpreter state machine
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state          <= sdci_pkg::SDCI_IDLE;
            bitcnt         <= 5'h00;
            atn_cnt        <= 4'h0;
            cmd_complete_o <= 1'b0;
            attention_o    <= 1'b0;
        end else begin
            case (state)
                sdci_pkg::SDCI_IDLE: begin
                    bitcnt         <= 5'h00;
                    cmd_complete_o <= !next_hold;
                    // first request edge opens a command
                    if (drive_selected_o && req_s && !xfer_ack_o && !hold && cmd_complete_o) begin
                        state          <= sdci_pkg::SDCI_RECV;
                        cmd_complete_o <= 1'b0;
                        attention_o    <= 1'b0;
                    end
                end
                sdci_pkg::SDCI_RECV: begin
                    if (hs_due && !req_s) bitcnt <= bitcnt + 5'h01;
                    if (bitcnt == `SDCI_XFER_BITS) state <= sdci_pkg::SDCI_DECODE;
                end
                sdci_pkg::SDCI_DECODE: begin
                    bitcnt <= 5'h00;
                    if (refuse) begin
                        state       <= sdci_pkg::SDCI_ATTN;
                        attention_o <= 1'b1;
                        atn_cnt     <= 4'h0;
                    end else if (op == `SDCI_OP_STATUS || op == `SDCI_OP_CONFIG) begin
                        state <= sdci_pkg::SDCI_SEND;
                    end else if (op == `SDCI_OP_MOTOR) begin
                        state <= sdci_pkg::SDCI_IDLE;
                    end else begin
                        state <= sdci_pkg::SDCI_EXEC;
                    end
                end
                sdci_pkg::SDCI_EXEC: begin
                    if (exec_done_i && exec_err_i) begin
                        state       <= sdci_pkg::SDCI_ATTN;
                        attention_o <= 1'b1;
                        atn_cnt     <= 4'h0;
                    end else if (exec_done_i) begin
                        state          <= sdci_pkg::SDCI_IDLE;
                        cmd_complete_o <= 1'b1;
                    end
                end
                sdci_pkg::SDCI_SEND: begin
                    if (hs_due && !req_s) bitcnt <= bitcnt + 5'h01;
                    if (bitcnt == `SDCI_XFER_BITS) begin
                        state          <= sdci_pkg::SDCI_IDLE;
                        cmd_complete_o <= 1'b1;
                    end
                end
                sdci_pkg::SDCI_ATTN: begin
                    atn_cnt <= atn_cnt + 4'h1;
                    if (atn_cnt == ATTN_LAST) begin
                        state          <= sdci_pkg::SDCI_IDLE;
                        cmd_complete_o <= 1'b1;
                    end
                end
                default: begin
                    state <= sdci_pkg::SDCI_IDLE;
                end
            endcase
        end
    end
    chk_attn_lead: assert property (($rose(cmd_complete_o) && attention_o)
        |-> $past(attention_o, 12))
        else $error("attention lead too short");
    chk_exec_done: assert property ((state == sdci_pkg::SDCI_EXEC && exec_done_i && !exec_err_i)
        |=> cmd_complete_o && !attention_o)
        else $error("complete missing after execution");
    chk_rx_count: assert property ($rose(state == sdci_pkg::SDCI_DECODE)
        |-> $past(bitcnt) == `SDCI_XFER_BITS)
        else $error("command word length wrong");
    // received and outgoing bit shifters
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_sh       <= 17'h00000;
            tx_sh       <= 17'h00000;
            resp_data_o <= 1'b0;
        end else begin
            if (state == sdci_pkg::SDCI_RECV && hs_due && req_s) rx_sh <= {rx_sh[15:0], dat_s};
            if (state == sdci_pkg::SDCI_DECODE) tx_sh <= {rsp_word, ~^rsp_word};
            if (state == sdci_pkg::SDCI_SEND) begin
                // bit driven before acknowledge rises
                if (hs_on && req_s && !xfer_ack_o && hs_cnt == 8'h00) resp_data_o <= tx_sh[16];
                if (hs_due && !req_s) tx_sh <= {tx_sh[15:0], 1'b0};
            end else begin
                resp_data_o <= 1'b0;
            end
        end
    end
    chk_tx_parity: assert property ($rose(state == sdci_pkg::SDCI_SEND) |-> ^tx_sh)
        else $error("response parity wrong");
    // command hand-off to the drive core
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            exec_start_o  <= 1'b0;
            motor_start_o <= 1'b0;
            motor_started <= 1'b0;
            exec_opcode_o <= 4'h0;
            exec_mod_o    <= 4'h0;
            exec_param_o  <= 12'h000;
        end else begin
            exec_start_o  <= 1'b0;
            motor_start_o <= 1'b0;
            if (state == sdci_pkg::SDCI_DECODE && !refuse) begin
                exec_opcode_o <= op;
                exec_param_o  <= rx_sh[`SDCI_PRM_MSB:`SDCI_PRM_LSB];
                exec_mod_o    <= PARAM_MASK[op] ? 4'h0 : rx_sh[`SDCI_MOD_MSB:`SDCI_MOD_LSB];
                if (op == `SDCI_OP_MOTOR) begin
                    motor_start_o <= 1'b1;
                    motor_started <= 1'b1;
                end else if (op != `SDCI_OP_STATUS && op != `SDCI_OP_CONFIG) begin
                    exec_start_o <= 1'b1;
                end
            end
        end
    end
    chk_parity_rej: assert property ((state == sdci_pkg::SDCI_DECODE && par_bad)
        |=> !exec_start_o && !motor_start_o && attention_o)
        else $error("bad parity executed");
    chk_invalid_op: assert property ((state == sdci_pkg::SDCI_DECODE && !IMPL_MASK[op])
        |=> !exec_start_o && attention_o)
        else $error("invalid opcode executed");
    chk_nrdy_block: assert property ((state == sdci_pkg::SDCI_DECODE && spin_fail_i && !spindle_ready_i
        && op != `SDCI_OP_STATUS) |=> !exec_start_o && !motor_start_o)
        else $error("command run while never ready");
    chk_decode_op: assert property ($rose(exec_start_o)
        |-> exec_opcode_o == $past(rx_sh[`SDCI_OP_MSB:`SDCI_OP_LSB]))
        else $error("opcode field wrong");
endmodule // sdci_top

// ===== sdci_host_model.sv
// Purpose: host controller model driving the serial command link
// Assumes: caller enters each task just after a rising edge of clk_i
// Notes: counts acknowledges that miss the 2 us window in slow_acks
`timescale 1ns/1ps
module sdci_host_model (
    // clock
    input  wire logic       clk_i,
    // from drive
    input  wire logic       xfer_ack_i,
    input  wire logic       resp_data_i,
    // to drive
    output logic      [2:0] drv_sel_o,
    output logic            xfer_req_o,
    output logic            cmd_data_o
);
    int slow_acks = 0;  // acks outside the window

    // idle levels at time zero
    initial begin
        drv_sel_o = 3'h0;
        xfer_req_o = 1'b0;
        cmd_data_o = 1'b0;
    end

    task automatic select(input logic [2:0] id);
        drv_sel_o <= id;
    endtask

    // wait for ack to reach a level, bounded
    task automatic wait_ack(input logic lvl, output logic r);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (xfer_ack_i !== lvl && n < 1000);
        r = resp_data_i;
        // ack about 2 us after req edge
        if (n < 240 || n > 265) slow_acks++;
    endtask

    // one interlocked bit: req up, ack up, req down, ack down
    task automatic xfer_bit(input logic b, output logic r);
        logic d;
        cmd_data_o <= b;
        xfer_req_o <= 1'b1;
        wait_ack(1'b1, r);
        xfer_req_o <= 1'b0;
        wait_ack(1'b0, d);
    endtask

    // msb first then odd parity, optionally broken
    task automatic send_word(input logic [15:0] w, input logic bad);
        logic r;
        for (int i = 15; i >= 0; i--) xfer_bit(w[i], r);
        xfer_bit(~^w ^ bad, r);
        cmd_data_o <= 1'b0;
    endtask

    task automatic read_word(output logic [15:0] w, output logic p);
        for (int i = 15; i >= 0; i--) xfer_bit(1'b0, w[i]);
        xfer_bit(1'b0, p);
    endtask

    // hold req a while and report ack level
    task automatic probe(output logic a);
        xfer_req_o <= 1'b1;
        repeat (400) @(posedge clk_i);
        a = xfer_ack_i;
        xfer_req_o <= 1'b0;
    endtask
endmodule // sdci_host_model

// ===== tb_serial_disk_command_interface.sv
// Purpose: self-checking bench for the serial disk command interface
// Assumes: drive id 5; straps and core levels change at mid-run resets
// Notes: each scenario task drives and judges before it returns
`timescale 1ns/1ps
module tb_serial_disk_command_interface;
    logic        mclk_i = 1'b0;   // 125 MHz clock
    logic        sys_rst_i = 1'b1;
    logic        spindle_ready_i = 1'b0;
    logic        exec_done_i = 1'b0;
    logic        exec_err_i = 1'b0;
    logic [15:0] status_word_i = 16'hA5C3;
    logic        motor_cmd_opt_i = 1'b0;    // start strap
    logic        spin_fail_i = 1'b0;        // spin-up failed for good
    logic [15:0] config_word_i = 16'h3C96;  // general configuration
    wire  [2:0]  drv_sel;
    wire         xfer_req, cmd_data, drive_selected_o, xfer_ack_o, resp_data_o;
    wire         cmd_complete_o, attention_o, ready_o, exec_start_o, motor_start_o;
    wire  [3:0]  exec_opcode_o, exec_mod_o;
    wire  [11:0] exec_param_o;
    int          fails = 0, checks_done = 0, cyc = 0, starts = 0, att_at = 0, motors = 0;
    logic [3:0]  cap_op, cap_mod;  // last started command
    logic [11:0] cap_prm;
    logic        att_q, cc_q;      // previous output levels

    always #4 mclk_i = ~mclk_i;

    sdci_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .drive_id_i(3'h5), .motor_cmd_opt_i(motor_cmd_opt_i),
        .drv_sel_i(drv_sel), .xfer_req_i(xfer_req), .cmd_data_i(cmd_data),
        .drive_selected_o(drive_selected_o), .xfer_ack_o(xfer_ack_o), .resp_data_o(resp_data_o),
        .cmd_complete_o(cmd_complete_o), .attention_o(attention_o), .ready_o(ready_o),
        .spindle_ready_i(spindle_ready_i), .spin_fail_i(spin_fail_i), .status_word_i(status_word_i),
        .config_word_i(config_word_i), .exec_done_i(exec_done_i), .exec_err_i(exec_err_i),
        .exec_start_o(exec_start_o), .exec_opcode_o(exec_opcode_o), .exec_mod_o(exec_mod_o),
        .exec_param_o(exec_param_o), .motor_start_o(motor_start_o));

    sdci_host_model host (.clk_i(mclk_i), .xfer_ack_i(xfer_ack_o), .resp_data_i(resp_data_o),
        .drv_sel_o(drv_sel), .xfer_req_o(xfer_req), .cmd_data_o(cmd_data));

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // compare and count
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask

    // bounded wait for command complete
    task automatic wait_cc(input int lim);
        int n;
        n = 0;
        while (cmd_complete_o !== 1'b1 && n < lim) begin
            @(posedge mclk_i);
            n++;
        end
    endtask

    // core pulse of execution done
    task automatic finish_exec(input logic err);
        exec_err_i <= err;
        exec_done_i <= 1'b1;
        @(posedge mclk_i);
        exec_done_i <= 1'b0;
        exec_err_i <= 1'b0;
    endtask

    // capture starts, time attention, cut hangs
    always @(posedge mclk_i) begin
        cyc++;
        if (motor_start_o === 1'b1) motors++;
        if (exec_start_o === 1'b1) begin
            starts++;
            cap_op = exec_opcode_o;
            cap_mod = exec_mod_o;
            cap_prm = exec_param_o;
        end
        if (attention_o === 1'b1 && att_q !== 1'b1) att_at = cyc;
        if (cmd_complete_o === 1'b1 && cc_q !== 1'b1 && attention_o === 1'b1)
            check("attention lead", 16'h1, {15'h0, (cyc - att_at >= 13)});
        att_q = attention_o;
        cc_q = cmd_complete_o;
        if (cyc == 98000) begin
            fails++;
            final_report();
        end
    end

    // silent until spindle ready, then complete
    task automatic s_power_up();
        logic a;
        host.select(3'h5);
        repeat (10) @(posedge mclk_i);
        host.probe(a);
        check("ack before ready", 16'h0, a);
        check("complete before ready", 16'h0, cmd_complete_o);
        spindle_ready_i <= 1'b1;
        wait_cc(50);
        check("complete at ready", 16'h1, cmd_complete_o);
        check("ready", 16'h1, ready_o);
    endtask

    // select and deselect within 1 us
    task automatic s_select();
        host.select(3'h6);
        repeat (125) @(posedge mclk_i);
        check("selected other id", 16'h0, drive_selected_o);
        host.select(3'h5);
        repeat (125) @(posedge mclk_i);
        check("selected own id", 16'h1, drive_selected_o);
    endtask

    // parameter type command runs once
    task automatic s_seek();
        int s0;
        wait_cc(10);
        s0 = starts;
        host.send_word(16'h0ABC, 1'b0);
        repeat (10) @(posedge mclk_i);
        check("seek starts", 16'h1, 16'(starts - s0));
        check("seek opcode", 16'h0, cap_op);
        check("seek modifier", 16'h0, cap_mod);
        check("seek cylinder", 16'h0ABC, cap_prm);
        check("complete in exec", 16'h0, cmd_complete_o);
        finish_exec(1'b0);
        wait_cc(10);
        check("seek complete", 16'h1, cmd_complete_o);
        check("seek attention", 16'h0, attention_o);
    endtask

    // modifier command, error while deselected
    task automatic s_long_op();
        wait_cc(10);
        host.send_word(16'h1500, 1'b0);
        repeat (10) @(posedge mclk_i);
        check("modifier opcode", 16'h1, cap_op);
        check("modifier code", 16'h5, cap_mod);
        host.select(3'h0);
        repeat (125) @(posedge mclk_i);
        check("released select", 16'h0, drive_selected_o);
        finish_exec(1'b1);
        repeat (30) @(posedge mclk_i);
        host.select(3'h5);
        repeat (125) @(posedge mclk_i);
        check("complete after reselect", 16'h1, cmd_complete_o);
        check("error attention", 16'h1, attention_o);
    endtask

    // general configuration then standard status, each with parity
    task automatic s_status();
        logic [15:0] w;
        logic [15:0] e;
        logic        p;
        for (int i = 0; i < 2; i++) begin
            e = (i == 0) ? 16'h3C96 : 16'hA5C3;
            wait_cc(10);
            host.send_word((i == 0) ? 16'h3000 : 16'h2000, 1'b0);
            repeat (4) @(posedge mclk_i);
            host.read_word(w, p);
            check("response word", e, w);
            check("response parity", {15'h0, ~^e}, p);
            wait_cc(20);
            check("response complete", 16'h1, cmd_complete_o);
            check("attention cleared", 16'h0, attention_o);
        end
    endtask

    // mid-run reset with new strap and core levels
    task automatic restart(input logic opt, input logic fail);
        sys_rst_i <= 1'b1;
        motor_cmd_opt_i <= opt;
        spin_fail_i <= fail;
        spindle_ready_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        wait_cc(20);
        repeat (4) @(posedge mclk_i);
    endtask

    // spindle never ready: other commands refused but completed
    task automatic s_never_ready();
        int s0;
        restart(1'b0, 1'b1);
        check("complete never ready", 16'h1, cmd_complete_o);
        s0 = starts;
        host.send_word(16'h0ABC, 1'b0);
        wait_cc(40);
        check("never ready complete", 16'h1, cmd_complete_o);
        check("never ready attention", 16'h1, attention_o);
        check("never ready starts", 16'h0, 16'(starts - s0));
        check("never ready level", 16'h0, ready_o);
    endtask

    // start by command: motor start, silent until at speed
    task automatic s_motor_cmd();
        int m0;
        restart(1'b1, 1'b0);
        check("complete before motor start", 16'h1, cmd_complete_o);
        m0 = motors;
        host.send_word(16'h5000, 1'b0);
        repeat (40) @(posedge mclk_i);
        check("motor start pulses", 16'h1, 16'(motors - m0));
        check("complete while spinning", 16'h0, cmd_complete_o);
        spindle_ready_i <= 1'b1;
        wait_cc(20);
        check("complete at speed", 16'h1, cmd_complete_o);
        check("ready at speed", 16'h1, ready_o);
    endtask

    // bad parity and unimplemented opcode refused
    task automatic s_refused();
        logic [15:0] cmds [2];
        logic        bads [2];
        int          s0;
        cmds = '{16'h0123, 16'hF000};
        bads = '{1'b1, 1'b0};
        for (int i = 0; i < 2; i++) begin
            wait_cc(10);
            s0 = starts;
            host.send_word(cmds[i], bads[i]);
            wait_cc(40);
            check("refused complete", 16'h1, cmd_complete_o);
            check("refused attention", 16'h1, attention_o);
            check("refused starts", 16'h0, 16'(starts - s0));
        end
        check("slow acks", 16'h0, 16'(host.slow_acks));
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        s_power_up();
        s_select();
        s_seek();
        s_long_op();
        s_status();
        s_refused();
        s_never_ready();
        s_motor_cmd();
        final_report();
    end
endmodule // tb_serial_disk_command_interface
